// >>> verilog/adtc_top.sv
// threshold compare, error calculation and trigger select with an ahb-lite slave
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "adtc_params.svh"

module adtc_top #(
    parameter int NUM_TRIG = 32                  // number of trigger source pins
) (
    input  wire logic                  clk,          // system clock, 125 MHz
    input  wire logic                  rst_b,        // async reset, active low
    input  wire logic                  hsel,         // slave select
    input  wire logic [31:0]           haddr,        // byte address
    input  wire logic [1:0]            htrans,       // transfer type
    input  wire logic                  hwrite,       // write when high
    input  wire logic [2:0]            hsize,        // word transfers only
    input  wire logic [31:0]           hwdata,       // write data
    input  wire logic                  hready,       // bus ready
    output logic                       hreadyout,    // slave ready
    output logic                       hresp,        // always okay
    output logic [31:0]                hrdata,       // read data
    input  wire adtc_pkg::adtc_calc_in_t calc_in,    // calculation operands
    input  wire logic                  calc_done,    // operands valid, pulse
    input  wire logic [NUM_TRIG-1:0]   trig_src,     // async trigger pins
    output logic                       start_conv,   // conversion start pulse
    output logic [4:0]                 auto_trigger_select, // trigger select
    output logic [2:0]                 error_calc_select,   // calculation select
    output logic [15:0]                computed_error_value,// last error value
    output logic                       above_upper_flag,    // error above upper
    output logic                       below_lower_flag,    // error below lower
    output logic                       irq                  // level interrupt
);

    // the pin falls at once, the release waits
    // two edges so no flop sees it near an edge
    // reset release through two flops
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;
    // every other flop but the threshold registers resets from this copy

    // ------------ functions ------------
    // pure decoders, kept out of the datapath
    // error calculation for a given select value
    // differences wrap at 16 bits
    // selects 4 to 7 act as select 1
    function automatic logic [15:0] calc_err(input logic [2:0] sel,
                                             input adtc_pkg::adtc_calc_in_t c);
        logic [15:0] r;
        r = 16'h0000;
        case (sel)
            3'h0:    r = 16'(c.result - c.prev);      // first derivative
            3'h1:    r = 16'(c.result - c.setpoint);  // result against setpoint
            3'h2:    r = 16'(c.filter - c.setpoint);  // filtered against setpoint
            3'h3:    r = 16'(c.prev - c.setpoint);    // previous against setpoint
            default: r = 16'(c.result - c.setpoint);
        endcase
        return r;
    endfunction : calc_err

    // does the comparison outcome satisfy the mode
    // with crossed thresholds both flags may set;
    // each mode still decodes, though maybe never met
    function automatic logic mode_hit(input logic [2:0] mode,
                                      input logic below,
                                      input logic above);
        logic h;
        h = 1'b0;
        case (adtc_pkg::adtc_tmode_t'(mode))
            adtc_pkg::ADTC_TMD_NEVER:   h = 1'b0;
            adtc_pkg::ADTC_TMD_BELOW:   h = below;
            adtc_pkg::ADTC_TMD_NBELOW:  h = !below;
            adtc_pkg::ADTC_TMD_OUTSIDE: h = below | above;
            adtc_pkg::ADTC_TMD_INSIDE:  h = !below & !above;
            adtc_pkg::ADTC_TMD_NABOVE:  h = !above;
            adtc_pkg::ADTC_TMD_ABOVE:   h = above;
            adtc_pkg::ADTC_TMD_ALWAYS:  h = 1'b1;
            default:                    h = 1'b0;
        endcase
        return h;
    endfunction : mode_hit

    // ------------ bus slave ------------
    // writes end at once, reads wait one cycle,
    // so hready low only ever follows a read
    // hresp stays low: every access ends okay
    adtc_pkg::adtc_state_t   st_q;
    adtc_pkg::adtc_state_t   st_d;
    adtc_pkg::adtc_bus_req_t req_q;
    logic                    ready_q;
    logic [31:0]             rdata_q;
    logic                    resp_q;

    // nothing is taken while a read waits
    // a transfer is taken on a valid address phase while the bus is ready
    wire take    = hsel & htrans[1] & hready;
    wire in_wr   = (st_q == adtc_pkg::ADTC_ST_WR);
    wire in_rd   = (st_q == adtc_pkg::ADTC_ST_RD);
    wire wr_en   = in_wr;
    wire [7:0] wa = req_q.addr;

    // a read's wait cycle meets no new request
    // next state: reads take one wait state so they never see stale writes
    always_comb begin
        st_d = adtc_pkg::ADTC_ST_IDLE;
        case (st_q)
            adtc_pkg::ADTC_ST_IDLE,
            adtc_pkg::ADTC_ST_WR: begin
                if (take) begin
                    st_d = hwrite ? adtc_pkg::ADTC_ST_WR : adtc_pkg::ADTC_ST_RD;
                end
            end
            adtc_pkg::ADTC_ST_RD: st_d = adtc_pkg::ADTC_ST_IDLE;
            default:              st_d = adtc_pkg::ADTC_ST_IDLE;
        endcase
    end

    // the request is kept from the address phase
    // state, captured request and ready flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= adtc_pkg::ADTC_ST_IDLE;
            req_q   <= '0;
            ready_q <= 1'b1;
            resp_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            resp_q  <= 1'b0;
            // ready drops only for a read taken now
            ready_q <= !(take & !hwrite & !in_rd);
            if (take && !in_rd) begin
                req_q <= '{addr: haddr[7:0], write: hwrite};
            end
        end
    end

    // write strobes per register
    // strobes use the captured address, so they
    // are high in the data phase, with hwdata
    wire w_lth_lo = wr_en & (wa == `ADTC_OFF_LTH_LO);
    wire w_lth_hi = wr_en & (wa == `ADTC_OFF_LTH_HI);
    wire w_uth_lo = wr_en & (wa == `ADTC_OFF_UTH_LO);
    wire w_uth_hi = wr_en & (wa == `ADTC_OFF_UTH_HI);
    wire w_trig   = wr_en & (wa == `ADTC_OFF_TRIG);
    wire w_ctrl3  = wr_en & (wa == `ADTC_OFF_CTRL3);
    wire w_istat  = wr_en & (wa == `ADTC_OFF_ISTAT);
    wire w_imask  = wr_en & (wa == `ADTC_OFF_IMASK);
    wire w_cmd    = wr_en & (wa == `ADTC_OFF_CMD);

    // ------------ threshold registers ------------
    // each threshold is a low and a high byte
    logic [15:0] lth_q;
    logic [15:0] uth_q;
    // bytes land one at a time, so the compare may
    // see a half-written value between the writes
    // data registers, no reset on purpose: contents are unknown after reset
    always_ff @(posedge clk) begin
        if (w_lth_lo) lth_q[7:0]  <= hwdata[7:0];
        if (w_lth_hi) lth_q[15:8] <= hwdata[7:0];
        if (w_uth_lo) uth_q[7:0]  <= hwdata[7:0];
        if (w_uth_hi) uth_q[15:8] <= hwdata[7:0];
    end

    // ------------ control registers ------------
    // unstored bits above a field read zero
    // mode and calc select share control word three
    logic [4:0] trig_q;
    logic [2:0] tmd_q;
    logic [2:0] calc_q;
    logic [2:0] imask_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q  <= `ADTC_RST_TRIG;
            tmd_q   <= 3'(`ADTC_RST_CTRL3 >> `ADTC_TMD_LSB);
            calc_q  <= 3'h0;
            imask_q <= `ADTC_RST_IMASK;
        end else begin
            // only the low five bits land, bits 31 to 5 are dropped
            if (w_trig)  trig_q <= hwdata[`ADTC_TRIG_MSB:`ADTC_TRIG_LSB];
            if (w_ctrl3) tmd_q  <= hwdata[`ADTC_TMD_MSB:`ADTC_TMD_LSB];
            if (w_ctrl3) calc_q <= hwdata[`ADTC_CALC_MSB:`ADTC_CALC_LSB];
            if (w_imask) imask_q <= hwdata[2:0];
        end
    end

    // ------------ error calculation and compare ------------
    // signed compare: 16'hff00 is minus 256
    // an error equal to a threshold sets no flag
    // operands count only while calc_done is high
    wire [15:0] err_d   = calc_err(calc_q, calc_in);
    wire        below_d = $signed(err_d) < $signed(lth_q);
    wire        above_d = $signed(err_d) > $signed(uth_q);
    wire        thr_ev  = calc_done & mode_hit(tmd_q, below_d, above_d);

    // registered copies, seen by ports and bus
    logic [15:0] err_q;
    logic        above_q;
    logic        below_q;
    // result and flags update together on every finished calculation
    // both flags change on one edge, never apart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q   <= 16'h0000;
            above_q <= 1'b0;
            below_q <= 1'b0;
        end else if (calc_done) begin
            err_q   <= err_d;
            above_q <= above_d;
            below_q <= below_d;
        end
    end

    // ------------ trigger pins ------------
    // one capture chain per pin
    logic [NUM_TRIG-1:0] ts1_q;
    logic [NUM_TRIG-1:0] ts2_q;
    logic [NUM_TRIG-1:0] ts3_q;
    logic [NUM_TRIG-1:0] tlev_q;
    logic                sel_prev_q;
    genvar g;
    // three-stage capture, a level counts once stages two and three agree
    // a level must stand two samples, so a glitch
    // shorter than a clock starts nothing
    generate
        for (g = 0; g < NUM_TRIG; g++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ts1_q[g]  <= 1'b0;
                    ts2_q[g]  <= 1'b0;
                    ts3_q[g]  <= 1'b0;
                    tlev_q[g] <= 1'b0;
                end else begin
                    ts1_q[g] <= trig_src[g];
                    ts2_q[g] <= ts1_q[g];
                    ts3_q[g] <= ts2_q[g];
                    if (ts2_q[g] == ts3_q[g]) tlev_q[g] <= ts3_q[g];
                end
            end
        end
    endgenerate

    // selected source; index zero is no source at all
    // a select past the pin count acts as zero
    // only a rising edge fires, not a held level
    wire sel_ok   = (trig_q != 5'h00) && (32'(trig_q) < NUM_TRIG);
    wire sel_lev  = sel_ok & tlev_q[trig_q];
    wire auto_ev  = sel_lev & !sel_prev_q;      // rising edge starts a conversion
    wire go_ev    = w_cmd & hwdata[`ADTC_CMD_GO];

    // ------------ interrupt status ------------
    // bit 0 threshold, 1 calc done, 2 auto trigger
    // written ones clear, written zeros leave alone
    logic [2:0] ist_q;
    wire  [2:0] ist_set = {auto_ev, calc_done, thr_ev};
    wire  [2:0] ist_clr = w_istat ? hwdata[2:0] : 3'h0;
    // a new event in the clearing cycle wins over the clear
    // a clear never hides a same-cycle event
    wire  [2:0] ist_d   = (ist_q & ~ist_clr) | ist_set;

    // irq uses the next status, rising with it
    logic start_q;
    logic irq_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_q      <= `ADTC_RST_IST;
            sel_prev_q <= 1'b0;
            start_q    <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            ist_q      <= ist_d;
            sel_prev_q <= sel_lev;
            start_q    <= auto_ev | go_ev;
            irq_q      <= |(ist_d & imask_q);
        end
    end

    // ------------ read path ------------
    // address bits above 7 are not decoded
    wire [7:0] ra = req_q.addr;
    // status: above flag bit 6, below flag bit 5
    wire [31:0] cstat_w = {25'h0, above_q, below_q, 5'h00};
    // read mux, unmapped offsets read zero
    // the write-only command word reads zero
    wire [31:0] rd_mux =
        (ra == `ADTC_OFF_LTH_LO) ? {24'h0, lth_q[7:0]}  :
        (ra == `ADTC_OFF_LTH_HI) ? {24'h0, lth_q[15:8]} :
        (ra == `ADTC_OFF_UTH_LO) ? {24'h0, uth_q[7:0]}  :
        (ra == `ADTC_OFF_UTH_HI) ? {24'h0, uth_q[15:8]} :
        (ra == `ADTC_OFF_TRIG)   ? {27'h0, trig_q}      :
        (ra == `ADTC_OFF_CTRL3)  ? {25'h0, calc_q, 1'b0, tmd_q} :
        (ra == `ADTC_OFF_CSTAT)  ? cstat_w                :
        (ra == `ADTC_OFF_ISTAT)  ? {29'h0, ist_q}         :
        (ra == `ADTC_OFF_IMASK)  ? {29'h0, imask_q}       :
        (ra == `ADTC_OFF_ERR)    ? {16'h0, err_q}         :
        32'h0000_0000;

    // read data is loaded in the wait cycle, after any earlier write landed
    // hrdata holds until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (in_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // ------------ outputs, all from flops ------------
    // each output is a flop copy, no logic after,
    // so no glitch reaches the pins
    assign hreadyout            = ready_q;
    assign hresp                = resp_q;
    assign hrdata               = rdata_q;
    assign start_conv           = start_q;
    assign auto_trigger_select  = trig_q;
    assign error_calc_select    = calc_q;
    assign computed_error_value = err_q;
    assign above_upper_flag     = above_q;
    assign below_lower_flag     = below_q;
    assign irq                  = irq_q;

    // hsize is not checked: only whole-word accesses are expected
    // byte or halfword access acts as a word
    wire unused_ok = &{1'b0, hsize, haddr[31:8], req_q.write, hwdata[31:8]};

endmodule : adtc_top
`default_nettype wire

// >>> common/adtc_params.svh
// register offsets, field positions and reset values of the threshold block
`ifndef ADTC_PARAMS_SVH
`define ADTC_PARAMS_SVH

// byte offsets inside the block's window (address bits 7:0)
`define ADTC_OFF_LTH_LO   8'h00
`define ADTC_OFF_LTH_HI   8'h04
`define ADTC_OFF_UTH_LO   8'h08
`define ADTC_OFF_UTH_HI   8'h0c
`define ADTC_OFF_TRIG     8'h10
`define ADTC_OFF_CTRL3    8'h14
`define ADTC_OFF_CSTAT    8'h18
`define ADTC_OFF_ISTAT    8'h1c
`define ADTC_OFF_IMASK    8'h20
`define ADTC_OFF_ERR      8'h24
`define ADTC_OFF_CMD      8'h28

// field positions
`define ADTC_TRIG_LSB     0
`define ADTC_TRIG_MSB     4
`define ADTC_TMD_LSB      0
`define ADTC_TMD_MSB      2
`define ADTC_CALC_LSB     4
`define ADTC_CALC_MSB     6
`define ADTC_CST_ABOVE    6
`define ADTC_CST_BELOW    5
`define ADTC_IST_THR      0
`define ADTC_IST_DONE     1
`define ADTC_IST_TRIG     2
`define ADTC_CMD_GO       0

// reset values
`define ADTC_RST_TRIG     5'h00
`define ADTC_RST_CTRL3    7'h00
`define ADTC_RST_IST      3'h0
`define ADTC_RST_IMASK    3'h0

`endif

// >>> common/adtc_pkg.sv
// types shared by the threshold-compare and trigger-select block
package adtc_pkg;

    // bus slave states, one-hot
    typedef enum logic [2:0] {
        ADTC_ST_IDLE = 3'b001,
        ADTC_ST_WR   = 3'b010,
        ADTC_ST_RD   = 3'b100
    } adtc_state_t;

    // threshold interrupt modes
    typedef enum logic [2:0] {
        ADTC_TMD_NEVER   = 3'h0,
        ADTC_TMD_BELOW   = 3'h1,
        ADTC_TMD_NBELOW  = 3'h2,
        ADTC_TMD_OUTSIDE = 3'h3,
        ADTC_TMD_INSIDE  = 3'h4,
        ADTC_TMD_NABOVE  = 3'h5,
        ADTC_TMD_ABOVE   = 3'h6,
        ADTC_TMD_ALWAYS  = 3'h7
    } adtc_tmode_t;

    // captured address phase
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
    } adtc_bus_req_t;

    // operands of the error calculation
    typedef struct packed {
        logic [15:0] result;
        logic [15:0] prev;
        logic [15:0] filter;
        logic [15:0] setpoint;
    } adtc_calc_in_t;

endpackage : adtc_pkg

// >>> dv/adtc_chk_monitor.sv
// concurrent checks on the ports of the threshold and trigger block
`timescale 1ns/10ps
`default_nettype none
module adtc_chk_monitor #(
    parameter int NUM_TRIG = 32                          // trigger pin count
) (
    input wire logic                    clk,                  // clock
    input wire logic                    rst_b,                // reset, active low
    input wire logic                    hsel,                 // select
    input wire logic [31:0]             haddr,                // address
    input wire logic [1:0]              htrans,               // transfer type
    input wire logic                    hwrite,               // write
    input wire logic [2:0]              hsize,                // size
    input wire logic [31:0]             hwdata,               // write data
    input wire logic                    hready,               // bus ready
    input wire logic                    hreadyout,            // slave ready
    input wire logic                    hresp,                // response
    input wire logic [31:0]             hrdata,               // read data
    input wire adtc_pkg::adtc_calc_in_t calc_in,              // operands
    input wire logic                    calc_done,            // operands valid
    input wire logic [NUM_TRIG-1:0]     trig_src,             // trigger pins
    input wire logic                    start_conv,           // start pulse
    input wire logic [4:0]              auto_trigger_select,  // trigger select
    input wire logic [2:0]              error_calc_select,    // calc select
    input wire logic [15:0]             computed_error_value, // error value
    input wire logic                    above_upper_flag,     // above flag
    input wire logic                    below_lower_flag,     // below flag
    input wire logic                    irq                   // interrupt
);
    // a request is taken when selected, active and the bus is ready
    wire logic taken;
    assign taken = hsel && htrans[1] && hready;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read data phase not one wait state");
    property p_trig_rd; taken && !hwrite && haddr[7:0] == 8'h10 |=> ##1
        hrdata == {27'h0, auto_trigger_select}; endproperty
    a_trig_rd: assert property (p_trig_rd)
        else $error("trigger register read wrong");
    property p_trig_chg; !$stable(auto_trigger_select) |->
        $past(taken && hwrite && haddr[7:0] == 8'h10, 2); endproperty
    a_trig_chg: assert property (p_trig_chg)
        else $error("trigger select changed without a write");
    property p_rst; $rose(rst_b) |-> auto_trigger_select == 5'h00; endproperty
    a_rst: assert property (p_rst)
        else $error("trigger select not cleared by reset");
    property p_flag_hold; !calc_done |=> $stable({above_upper_flag, below_lower_flag}); endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flags moved without a calculation");
    property p_err_hold; !calc_done |=> $stable(computed_error_value); endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error value moved without a calculation");
    // irq drops two edges after a taken status clear, three after a mask write
    property p_irq_fall; $fell(irq) |->
        $past(taken && hwrite, 2) || $past(taken && hwrite, 3); endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
    property p_sw_start; taken && hwrite && haddr[7:0] == 8'h28 ##1 hwdata[0] |->
        ##[1:3] start_conv; endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start gave no pulse");
    property p_pulse; start_conv |=> !start_conv; endproperty
    a_pulse: assert property (p_pulse)
        else $error("start pulse longer than one cycle");
endmodule : adtc_chk_monitor

bind adtc_top adtc_chk_monitor #(.NUM_TRIG(NUM_TRIG)) i_chk (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .calc_in(calc_in), .calc_done(calc_done), .trig_src(trig_src),
    .start_conv(start_conv), .auto_trigger_select(auto_trigger_select),
    .error_calc_select(error_calc_select), .computed_error_value(computed_error_value),
    .above_upper_flag(above_upper_flag), .below_lower_flag(below_lower_flag), .irq(irq));
`default_nettype wire

// >>> dv/adtc_testbench.sv
// self-checking bench for the threshold compare and trigger select block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                    clk, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, calc_done = 1'b0;
    logic [31:0]             haddr = 32'h0, hwdata = 32'h0, trig_src = 32'h0, seed = 32'hf3f8f744;
    logic [31:0]             rdat, d;
    logic [1:0]              htrans = 2'h0;
    logic [2:0]              m, s;
    logic [15:0]             e;
    logic                    a, b, h;
    adtc_pkg::adtc_calc_in_t calc_in = '0, ci;
    wire logic               hreadyout, hresp, start_conv, above_upper_flag, below_lower_flag, irq;
    wire logic [31:0]        hrdata;
    wire logic [4:0]         auto_trigger_select;
    wire logic [2:0]         error_calc_select;
    wire logic [15:0]        computed_error_value;
    int                      errors = 0, check_count = 0, starts = 0, i, k, n0;

    // hready is the one slave's own hreadyout; hsize tied to word
    adtc_top #(.NUM_TRIG(32)) i_dut (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .calc_in(calc_in), .calc_done(calc_done), .trig_src(trig_src),
        .start_conv(start_conv), .auto_trigger_select(auto_trigger_select),
        .error_calc_select(error_calc_select), .computed_error_value(computed_error_value),
        .above_upper_flag(above_upper_flag), .below_lower_flag(below_lower_flag), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // count start pulses; sampled before the edge so never racing the design
    always @(posedge clk) if (start_conv === 1'b1) starts++;

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] exp_err(input logic [2:0] sel, input adtc_pkg::adtc_calc_in_t c);
        case (sel)
            3'h0: return c.result - c.prev;
            3'h2: return c.filter - c.setpoint;
            3'h3: return c.prev - c.setpoint;
            default: return c.result - c.setpoint;
        endcase
    endfunction : exp_err

    // one bit per mode, mode 0 at the bottom
    function automatic logic exp_hit(input logic [2:0] md, input logic bl, input logic ab);
        logic [7:0] t;
        t = {1'b1, ab, !ab, !bl && !ab, bl || ab, !bl, bl, 1'b0};
        return t[md];
    endfunction : exp_hit

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // one single transfer; holds each phase until hready is seen high
    task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdat = hrdata;
    endtask : xfer

    task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input string msg);
        xfer(ad, 1'b0, 32'h0);
        chk(rdat, exp, msg);
    endtask : rchk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // whole run is under a thousand cycles; this only cuts a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(8'h10, 32'h0, "trigger after reset");
        xfer(8'h2c, 1'b1, rnd());
        rchk(8'h2c, 32'h0, "unmapped read");
        chk(hresp, 1'b0, "okay response");
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            d = rnd();
            xfer(8'(4 * i), 1'b1, d);
            rchk(8'(4 * i), {24'h0, d[7:0]}, "threshold byte");
        end
        for (i = 0; i < 6; i++) begin
            d = rnd();
            xfer(8'h10, 1'b1, d);
            rchk(8'h10, {27'h0, d[4:0]}, "trigger readback");
            chk(auto_trigger_select, d[4:0], "trigger port");
        end
        $display("test registers done");
        // lower -256, upper 256, only the threshold event unmasked
        xfer(8'h00, 1'b1, 32'h00);
        xfer(8'h04, 1'b1, 32'hff);
        xfer(8'h08, 1'b1, 32'h00);
        xfer(8'h0c, 1'b1, 32'h01);
        xfer(8'h20, 1'b1, 32'h1);
        xfer(8'h1c, 1'b1, 32'h7);
        for (i = 0; i < 48; i++) begin
            m = i[2:0];
            s = 3'(rnd());
            ci = {rnd(), rnd()} & 64'h03ff_03ff_03ff_03ff;
            // first rounds put the error exactly on each threshold
            if (i < 16) begin
                s = 3'h0;
                ci = {(i < 8) ? 16'h0100 : 16'hff00, 48'h0};
            end
            xfer(8'h14, 1'b1, {25'h0, s, 1'b0, m});
            calc_in <= ci;
            calc_done <= 1'b1;
            @(posedge clk);
            calc_done <= 1'b0;
            e = exp_err(s, ci);
            b = $signed(e) < $signed(16'hff00);
            a = $signed(e) > $signed(16'h0100);
            h = exp_hit(m, b, a);
            repeat (2) @(posedge clk);
            chk(error_calc_select, s, "calc select port");
            chk(computed_error_value, e, "error value");
            chk({above_upper_flag, below_lower_flag}, {a, b}, "flags");
            chk(irq, h, "threshold irq");
            rchk(8'h18, {25'h0, a, b, 5'h0}, "status flags");
            rchk(8'h1c, {30'h0, 1'b1, h}, "event status");
            xfer(8'h1c, 1'b1, 32'h7);
        end
        $display("test compare done");
        xfer(8'h10, 1'b1, 32'h0);
        n0 = starts;
        trig_src <= 32'hffff_ffff;
        repeat (8) @(posedge clk);
        trig_src <= 32'h0;
        chk(starts - n0, 0, "no auto start at select zero");
        xfer(8'h28, 1'b1, 32'h1);
        repeat (8) @(posedge clk);
        chk(starts - n0, 1, "software start");
        for (i = 0; i < 6; i++) begin
            n0 = starts;
            k = 1 + int'(rnd() % 31);
            xfer(8'h1c, 1'b1, 32'h7);
            xfer(8'h10, 1'b1, k);
            trig_src[k] <= 1'b1;
            repeat (10) @(posedge clk);
            chk(starts - n0, 1, "auto start");
            rchk(8'h1c, 32'h4, "trigger event");
            trig_src <= 32'h0;
            repeat (6) @(posedge clk);
        end
        $display("test triggers done");
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk(auto_trigger_select, 5'h0, "trigger port after reset");
        rchk(8'h10, 32'h0, "trigger read after reset");
        $display("test second reset done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
